// [inc/motion_irq_pkg.sv]
// Package with register map, field layout, reset values and timing of the motion interrupt controller.
`default_nettype none
package motion_irq_pkg;
	// ============================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] REG_SLOPE_STATUS = 8'h09;
	localparam logic [7:0] REG_DATA_STATUS  = 8'h0A;
	localparam logic [7:0] REG_SLOPE_AXIS   = 8'h0B;
	localparam logic [7:0] REG_SLOPE_EN     = 8'h16;
	localparam logic [7:0] REG_DATA_EN      = 8'h17;
	localparam logic [7:0] REG_MAP_A        = 8'h19;
	localparam logic [7:0] REG_MAP_DATA     = 8'h1A;
	localparam logic [7:0] REG_MAP_B        = 8'h1B;
	localparam logic [7:0] REG_SRC_SEL      = 8'h1E;
	localparam logic [7:0] REG_PIN_CFG      = 8'h20;
	localparam logic [7:0] REG_CLEAR_MODE   = 8'h21;
	localparam logic [7:0] REG_SLOPE_DUR    = 8'h27;
	localparam logic [7:0] REG_THRESHOLD    = 8'h28;
	// ============================================================
	// Field positions
	localparam int BIT_SLOPE_ST   = 2;
	localparam int BIT_DATA_ST    = 7;
	localparam int BIT_SLOPE_SIGN = 3;
	localparam int BIT_DATA_EN    = 4;
	localparam int BIT_MAP_SLOPE  = 2;
	localparam int BIT_MAP_DATA_A = 0;
	localparam int BIT_MAP_DATA_B = 7;
	localparam int BIT_SRC_SLOPE  = 2;
	localparam int BIT_SRC_DATA   = 5;
	localparam int BIT_POL_A      = 0;
	localparam int BIT_OD_A       = 1;
	localparam int BIT_POL_B      = 2;
	localparam int BIT_OD_B       = 3;
	localparam int BIT_RESET_INT  = 7;
	// ============================================================
	// Writable bits and reset values
	localparam logic [7:0] MASK_SLOPE_EN  = 8'h07;
	localparam logic [7:0] MASK_DATA_EN   = 8'h10;
	localparam logic [7:0] MASK_MAP_A     = 8'h04;
	localparam logic [7:0] MASK_MAP_DATA  = 8'h81;
	localparam logic [7:0] MASK_MAP_B     = 8'h04;
	localparam logic [7:0] MASK_SRC_SEL   = 8'h24;
	localparam logic [7:0] MASK_PIN_CFG   = 8'h0F;
	localparam logic [7:0] MASK_MODE      = 8'h0F;
	localparam logic [7:0] MASK_DUR       = 8'h03;
	localparam logic [7:0] RST_THRESHOLD  = 8'h14;
	// ============================================================
	// Clear-mode codes and timing
	localparam logic [3:0] CODE_NONLATCH_0 = 4'h0;
	localparam logic [3:0] CODE_NONLATCH_1 = 4'h8;
	localparam logic [3:0] CODE_LATCH_0    = 4'h7;
	localparam logic [3:0] CODE_LATCH_1    = 4'hF;
	localparam int CLK_PERIOD_NS      = 10;
	localparam int HOLD_UNIT_US       = 500;
	localparam int HOLD_UNIT_CYCLES   = HOLD_UNIT_US * 1000 / CLK_PERIOD_NS;
	localparam int NEWDATA_LOW_US     = 50;
	localparam int NEWDATA_LOW_CYCLES = (NEWDATA_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		MODE_NONLATCHED = 3'b001,
		MODE_LATCHED    = 3'b010,
		MODE_TIMED      = 3'b100
	} clear_mode_t;
endpackage : motion_irq_pkg
`default_nettype wire

// [logic/motion_interrupt_controller.sv]
// Interrupt controller with new-data and any-motion engines, two routable pins and a Wishbone register slave.
// Function
// - Enabled condition sets status and mapped pin
// - Two pins, each OR of mapped interrupts
// - Status sets only with new sample
// - Disabling clears status and pin at once
// - Four-bit code selects nonlatched, latched or timed
// - No timed clearing while condition still holds
// - Nonlatched status follows condition; new-data self-clears
// - Latched clears by reset write, reasserts later
// - Timed status clears after selected hold
// - Source bit picks filtered or unfiltered data
// - Mapping bits route each interrupt per pin
// - Polarity bit sets each pin's active level
// - Drive bit selects push-pull or open-drain
// - Host ignores pins during first 2 ms; host model waits only 16 clock cycles
// - New-data sets on sample, low 50 us
// - New-data always nonlatched, own enable bit
// - Slope of successive samples against threshold
// - N consecutive samples set or clear slope
// - Axis enables; any sets, all must clear
// - Slope reports status, first axis and sign
// - Any axis enable runs engine; wake-up all
`default_nettype none
module motion_interrupt_controller
	import motion_irq_pkg::*;
#(
	parameter int ACC_W            = 10,
	parameter int ADDR_W           = 8,
	parameter int HOLD_TICK_CYCLES = HOLD_UNIT_CYCLES,
	parameter int NEWDATA_LOW      = NEWDATA_LOW_CYCLES
) (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	input  wire logic              clk_en_in,
	input  wire logic              wb_cyc_in,
	input  wire logic              wb_stb_in,
	input  wire logic              wb_we_in,
	input  wire logic [ADDR_W-1:0] wb_adr_in,
	input  wire logic [31:0]       wb_dat_in,
	input  wire logic [3:0]        wb_sel_in,
	output logic      [31:0]       wb_dat_out,
	output logic                   wb_ack_out,
	input  wire logic              sample_valid_in,
	input  wire logic              acq_start_in,
	input  wire logic              dedicated_wake_in,
	input  wire logic [ACC_W-1:0]  accel_filt_x_in,
	input  wire logic [ACC_W-1:0]  accel_filt_y_in,
	input  wire logic [ACC_W-1:0]  accel_filt_z_in,
	input  wire logic [ACC_W-1:0]  accel_unfilt_x_in,
	input  wire logic [ACC_W-1:0]  accel_unfilt_y_in,
	input  wire logic [ACC_W-1:0]  accel_unfilt_z_in,
	output logic                   irq_pin_a_out,
	output logic                   irq_pin_a_oe_out,
	output logic                   irq_pin_b_out,
	output logic                   irq_pin_b_oe_out
);
	// ============================================================
	// Parameter checks
	if (ACC_W < 9 || ACC_W > 16) $error("ACC_W must lie between 9 and 16");
	if (ADDR_W < 8) $error("ADDR_W must be at least 8");
	if (HOLD_TICK_CYCLES < 1 || HOLD_TICK_CYCLES > 100000) $error("HOLD_TICK_CYCLES out of range");
	if (NEWDATA_LOW < 1 || NEWDATA_LOW > 65535) $error("NEWDATA_LOW out of range");
	// ============================================================
	// State
	typedef struct packed {
		logic [7:0]              cfg_slope_en;
		logic [7:0]              cfg_data_en;
		logic [7:0]              cfg_map_a;
		logic [7:0]              cfg_map_data;
		logic [7:0]              cfg_map_b;
		logic [7:0]              cfg_src;
		logic [7:0]              cfg_pin;
		logic [7:0]              cfg_mode;
		logic [7:0]              cfg_dur;
		logic [7:0]              cfg_thr;
		logic                    slope_st;
		logic                    data_st;
		logic [2:0]              slope_axis;
		logic                    slope_sign;
		logic                    slope_cond;
		logic [2:0]              above_cnt;
		logic [2:0]              below_cnt;
		logic [2:0][ACC_W-1:0]   prev;
		logic                    prev_valid;
		logic [31:0]             hold_cnt;
		logic [15:0]             guard_cnt;
		logic                    pin_a;
		logic                    oe_a;
		logic                    pin_b;
		logic                    oe_b;
		logic                    ack;
		logic [31:0]             rdata;
	} state_t;
	// Inactive level of an active-low push-pull pin is high, driven.
	localparam state_t STATE_RESET = '{cfg_thr: RST_THRESHOLD, pin_a: 1'b1, oe_a: 1'b1,
		pin_b: 1'b1, oe_b: 1'b1, default: '0};
	state_t state_reg;
	state_t state_next;
	// ============================================================
	// Functions
	function automatic clear_mode_t decode_mode(input logic [3:0] code);
		case (code)
			CODE_NONLATCH_0, CODE_NONLATCH_1: decode_mode = MODE_NONLATCHED;
			CODE_LATCH_0, CODE_LATCH_1:       decode_mode = MODE_LATCHED;
			default:                          decode_mode = MODE_TIMED;
		endcase
	endfunction : decode_mode
	// Hold period in units of 500 us for each timed code.
	function automatic logic [15:0] hold_units(input logic [3:0] code);
		case (code)
			4'h1:    hold_units = 16'h01F4;
			4'h2:    hold_units = 16'h03E8;
			4'h3:    hold_units = 16'h07D0;
			4'h4:    hold_units = 16'h0FA0;
			4'h5:    hold_units = 16'h1F40;
			4'h6:    hold_units = 16'h3E80;
			4'h9:    hold_units = 16'h0001;
			4'hA:    hold_units = 16'h0001;
			4'hB:    hold_units = 16'h0002;
			4'hC:    hold_units = 16'h0019;
			4'hD:    hold_units = 16'h0032;
			4'hE:    hold_units = 16'h0064;
			default: hold_units = 16'h0000;
		endcase
	endfunction : hold_units
	// Returns {output enable, pin level}; open-drain only ever pulls low.
	function automatic logic [1:0] pin_drive(input logic active, input logic pol, input logic od);
		logic level;
		level     = ~(active ^ pol);
		pin_drive = {~od | ~level, level};
	endfunction : pin_drive
	// ============================================================
	// Slope datapath
	logic                  use_unfilt;
	logic [2:0][ACC_W-1:0] cur_sample;
	logic [2:0]            axis_above;
	logic [2:0]            axis_neg;
	logic [2:0]            axes_en;
	logic                  slope_on;
	assign use_unfilt    = state_reg.cfg_src[BIT_SRC_SLOPE];
	assign cur_sample[0] = use_unfilt ? accel_unfilt_x_in : accel_filt_x_in;
	assign cur_sample[1] = use_unfilt ? accel_unfilt_y_in : accel_filt_y_in;
	assign cur_sample[2] = use_unfilt ? accel_unfilt_z_in : accel_filt_z_in;
	assign axes_en       = dedicated_wake_in ? 3'h7 : state_reg.cfg_slope_en[2:0];
	assign slope_on      = |axes_en;
	for (genvar i = 0; i < 3; i++) begin : g_axis
		logic signed [ACC_W:0] diff;
		logic [ACC_W:0]        mag;
		assign diff = $signed({cur_sample[i][ACC_W-1], cur_sample[i]})
			- $signed({state_reg.prev[i][ACC_W-1], state_reg.prev[i]});
		assign mag           = diff[ACC_W] ? -diff : diff;
		assign axis_above[i] = mag > {{(ACC_W-7){1'b0}}, state_reg.cfg_thr};
		assign axis_neg[i]   = diff[ACC_W];
	end
	// ============================================================
	// Bus decode
	logic [7:0]  idx;
	logic        bus_req;
	logic        bus_wr;
	logic        reset_int_wr;
	clear_mode_t mode;
	logic [2:0]  dur_n;
	logic [31:0] hold_target;
	logic        pin_a_act;
	logic        pin_b_act;
	assign idx          = 8'(wb_adr_in >> 2);
	assign bus_req      = wb_cyc_in && wb_stb_in && !state_reg.ack;
	assign bus_wr       = bus_req && wb_we_in && wb_sel_in[0];
	assign reset_int_wr = bus_wr && idx == REG_CLEAR_MODE && wb_dat_in[BIT_RESET_INT];
	assign mode         = decode_mode(state_reg.cfg_mode[3:0]);
	assign dur_n        = {1'b0, state_reg.cfg_dur[1:0]} + 3'h1;
	assign hold_target  = 32'(hold_units(state_reg.cfg_mode[3:0])) * 32'(HOLD_TICK_CYCLES);
	assign pin_a_act    = (state_reg.slope_st && state_reg.cfg_map_a[BIT_MAP_SLOPE])
		|| (state_reg.data_st && state_reg.cfg_map_data[BIT_MAP_DATA_A]);
	assign pin_b_act    = (state_reg.slope_st && state_reg.cfg_map_b[BIT_MAP_SLOPE])
		|| (state_reg.data_st && state_reg.cfg_map_data[BIT_MAP_DATA_B]);
	// ============================================================
	// Next state
	always_comb
	begin
		logic [2:0] first_ax;
		logic       any_above;
		logic       act_a;
		logic       act_b;
		logic [1:0] drv;
		first_ax   = '0;
		any_above  = 1'b0;
		act_a      = 1'b0;
		act_b      = 1'b0;
		drv        = '0;
		state_next = state_reg;
		// Register writes; reserved bits are masked off and read as zero.
		state_next.ack = bus_req;
		if (bus_wr)
		begin
			unique case (idx)
				REG_SLOPE_EN:   state_next.cfg_slope_en = wb_dat_in[7:0] & MASK_SLOPE_EN;
				REG_DATA_EN:    state_next.cfg_data_en  = wb_dat_in[7:0] & MASK_DATA_EN;
				REG_MAP_A:      state_next.cfg_map_a    = wb_dat_in[7:0] & MASK_MAP_A;
				REG_MAP_DATA:   state_next.cfg_map_data = wb_dat_in[7:0] & MASK_MAP_DATA;
				REG_MAP_B:      state_next.cfg_map_b    = wb_dat_in[7:0] & MASK_MAP_B;
				REG_SRC_SEL:    state_next.cfg_src      = wb_dat_in[7:0] & MASK_SRC_SEL;
				REG_PIN_CFG:    state_next.cfg_pin      = wb_dat_in[7:0] & MASK_PIN_CFG;
				REG_CLEAR_MODE: state_next.cfg_mode     = wb_dat_in[7:0] & MASK_MODE;
				REG_SLOPE_DUR:  state_next.cfg_dur      = wb_dat_in[7:0] & MASK_DUR;
				REG_THRESHOLD:  state_next.cfg_thr      = wb_dat_in[7:0];
				default:        state_next.ack          = bus_req;
			endcase
		end
		// Any-motion engine, advanced only when a new sample lands.
		if (sample_valid_in)
		begin
			state_next.prev       = cur_sample;
			state_next.prev_valid = 1'b1;
			if (state_reg.prev_valid && slope_on)
			begin
				any_above = |(axis_above & axes_en);
				if (any_above)
				begin
					state_next.above_cnt = (state_reg.above_cnt == 3'h4) ? 3'h4 : state_reg.above_cnt + 3'h1;
					state_next.below_cnt = '0;
				end
				else
				begin
					state_next.below_cnt = (state_reg.below_cnt == 3'h4) ? 3'h4 : state_reg.below_cnt + 3'h1;
					state_next.above_cnt = '0;
				end
				if (state_next.above_cnt >= dur_n)
					state_next.slope_cond = 1'b1;
				else if (state_next.below_cnt >= dur_n)
					state_next.slope_cond = 1'b0;
			end
		end
		// Timed hold counts while the slope status is up and saturates at its target.
		if (state_reg.slope_st && state_reg.hold_cnt < hold_target)
			state_next.hold_cnt = state_reg.hold_cnt + 32'h1;
		// Clearing of the slope status comes first so that a set in the same cycle wins.
		if (reset_int_wr && mode != MODE_NONLATCHED)
		begin
			state_next.slope_st   = 1'b0;
			state_next.slope_axis = '0;
		end
		if (mode == MODE_TIMED && state_reg.slope_st && state_reg.hold_cnt >= hold_target
			&& !state_reg.slope_cond)
		begin
			state_next.slope_st   = 1'b0;
			state_next.slope_axis = '0;
		end
		if (sample_valid_in)
		begin
			first_ax = (axis_above & axes_en) & (~(axis_above & axes_en) + 3'h1);
			unique case (mode)
				MODE_NONLATCHED:
				begin
					state_next.slope_st = state_next.slope_cond;
					if (!state_next.slope_cond)
						state_next.slope_axis = '0;
				end
				MODE_LATCHED, MODE_TIMED:
				begin
					if (state_next.slope_cond)
						state_next.slope_st = 1'b1;
				end
			endcase
			if (state_next.slope_cond && !state_reg.slope_st && first_ax != 3'h0)
			begin
				state_next.slope_st   = 1'b1;
				state_next.slope_axis = first_ax;
				state_next.slope_sign = |(first_ax & axis_neg);
				state_next.hold_cnt   = '0;
			end
		end
		if (!slope_on)
		begin
			state_next.slope_st   = 1'b0;
			state_next.slope_axis = '0;
			state_next.slope_cond = 1'b0;
			state_next.above_cnt  = '0;
			state_next.below_cnt  = '0;
		end
		// New-data interrupt ignores the common clear mode.
		if (state_reg.guard_cnt != 16'h0)
			state_next.guard_cnt = state_reg.guard_cnt - 16'h1;
		if (acq_start_in && state_reg.data_st)
		begin
			state_next.data_st   = 1'b0;
			state_next.guard_cnt = 16'(NEWDATA_LOW);
		end
		if (sample_valid_in && state_reg.cfg_data_en[BIT_DATA_EN] && state_reg.guard_cnt == 16'h0)
		begin
			state_next.data_st   = 1'b1;
			state_next.guard_cnt = '0;
		end
		if (!state_reg.cfg_data_en[BIT_DATA_EN])
			state_next.data_st = 1'b0;
		// Pins follow the status registered at the same edge.
		act_a = (state_next.slope_st && state_next.cfg_map_a[BIT_MAP_SLOPE])
			|| (state_next.data_st && state_next.cfg_map_data[BIT_MAP_DATA_A]);
		act_b = (state_next.slope_st && state_next.cfg_map_b[BIT_MAP_SLOPE])
			|| (state_next.data_st && state_next.cfg_map_data[BIT_MAP_DATA_B]);
		drv = pin_drive(act_a, state_next.cfg_pin[BIT_POL_A], state_next.cfg_pin[BIT_OD_A]);
		state_next.pin_a = drv[0];
		state_next.oe_a  = drv[1];
		drv = pin_drive(act_b, state_next.cfg_pin[BIT_POL_B], state_next.cfg_pin[BIT_OD_B]);
		state_next.pin_b = drv[0];
		state_next.oe_b  = drv[1];
		// Read data is captured with the acknowledge.
		state_next.rdata = '0;
		if (bus_req && !wb_we_in)
		begin
			unique case (idx)
				REG_SLOPE_STATUS: state_next.rdata[BIT_SLOPE_ST] = state_reg.slope_st;
				REG_DATA_STATUS:  state_next.rdata[BIT_DATA_ST]  = state_reg.data_st;
				REG_SLOPE_AXIS:   state_next.rdata[7:0] = {4'h0, state_reg.slope_sign, state_reg.slope_axis};
				REG_SLOPE_EN:     state_next.rdata[7:0] = state_reg.cfg_slope_en;
				REG_DATA_EN:      state_next.rdata[7:0] = state_reg.cfg_data_en;
				REG_MAP_A:        state_next.rdata[7:0] = state_reg.cfg_map_a;
				REG_MAP_DATA:     state_next.rdata[7:0] = state_reg.cfg_map_data;
				REG_MAP_B:        state_next.rdata[7:0] = state_reg.cfg_map_b;
				REG_SRC_SEL:      state_next.rdata[7:0] = state_reg.cfg_src;
				REG_PIN_CFG:      state_next.rdata[7:0] = state_reg.cfg_pin;
				REG_CLEAR_MODE:   state_next.rdata[7:0] = state_reg.cfg_mode;
				REG_SLOPE_DUR:    state_next.rdata[7:0] = state_reg.cfg_dur;
				REG_THRESHOLD:    state_next.rdata[7:0] = state_reg.cfg_thr;
				default:          state_next.rdata      = '0;
			endcase
		end
	end
	// ============================================================
	// Registers
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state_reg <= STATE_RESET;
		else if (clk_en_in)
			state_reg <= state_next;
	end
	assign wb_dat_out       = state_reg.rdata;
	assign wb_ack_out       = state_reg.ack;
	assign irq_pin_a_out    = state_reg.pin_a;
	assign irq_pin_a_oe_out = state_reg.oe_a;
	assign irq_pin_b_out    = state_reg.pin_b;
	assign irq_pin_b_oe_out = state_reg.oe_b;
	// ============================================================
	// Assertions
	sequence bus_req_s;
		clk_en_in && wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence sample_s;
		clk_en_in && sample_valid_in;
	endsequence
	bus_ack_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		bus_req_s |=> wb_ack_out and (clk_en_in |=> !wb_ack_out))
		else $error("bus acknowledge not a single cycle after request");
	data_disable_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(clk_en_in && !state_reg.cfg_data_en[BIT_DATA_EN]) |=> !state_reg.data_st)
		else $error("new-data status stayed up while disabled");
	slope_disable_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(clk_en_in && !slope_on) |=> !state_reg.slope_st && state_reg.slope_axis == 3'h0)
		else $error("slope status stayed up with no axis enabled");
	status_on_sample_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		($rose(state_reg.slope_st) || $rose(state_reg.data_st)) |-> $past(sample_valid_in))
		else $error("status rose without a sample update");
	latch_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(clk_en_in && state_reg.slope_st && mode == MODE_LATCHED && !reset_int_wr && slope_on)
		|=> state_reg.slope_st)
		else $error("latched slope status dropped without reset write");
	nonlatch_follow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(sample_s and (mode == MODE_NONLATCHED && !state_next.slope_cond))
		|=> !state_reg.slope_st)
		else $error("nonlatched slope status outlived its condition");
	newdata_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg.guard_cnt != 16'h0) |-> !state_reg.data_st)
		else $error("new-data status high inside its low time");
	pin_a_level_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		irq_pin_a_out == !(pin_a_act ^ state_reg.cfg_pin[BIT_POL_A]))
		else $error("first pin does not show its mapped interrupts");
	pin_b_level_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		irq_pin_b_out == !(pin_b_act ^ state_reg.cfg_pin[BIT_POL_B]))
		else $error("second pin level ignores its polarity");
	open_drain_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg.cfg_pin[BIT_OD_A] && irq_pin_a_out) |-> !irq_pin_a_oe_out)
		else $error("open-drain pin driven high");
	timed_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(clk_en_in && mode == MODE_TIMED && state_reg.slope_st && state_reg.hold_cnt >= hold_target
		&& !state_reg.slope_cond && !sample_valid_in && !bus_wr) |=> !state_reg.slope_st)
		else $error("timed slope status not cleared at end of hold");
endmodule : motion_interrupt_controller
`default_nettype wire

// [bench/irq_host_model.sv]
// Host-side model that resolves the two interrupt wires and waits out the power-up window.
`default_nettype none
module irq_host_model #(
	parameter int IGNORE_CYCLES = 16
) (
	input  wire logic clk_sys_in,
	input  wire logic pin_a_in,
	input  wire logic oe_a_in,
	input  wire logic pin_b_in,
	input  wire logic oe_b_in,
	output logic      level_a_out,
	output logic      level_b_out,
	output logic      ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int count = 0;
	// ============================================================
	// Wire level
	// An undriven wire rests at the pull-up, so open-drain release reads high.
	assign level_a_out = oe_a_in ? pin_a_in : 1'b1;
	assign level_b_out = oe_b_in ? pin_b_in : 1'b1;
	// Pin states are not trusted until the power-up window has passed.
	always @(posedge clk_sys_in)
		if (count < IGNORE_CYCLES)
			count <= count + 1;
	assign ready_out = (count >= IGNORE_CYCLES);
endmodule : irq_host_model
`default_nettype wire

// [bench/motion_interrupt_controller_tb.sv]
// Self-checking bench for the motion interrupt controller.
`default_nettype none
module motion_interrupt_controller_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import motion_irq_pkg::*;
	logic clk_sys_in = 0, rst_n_in = 0, cyc = 0, stb = 0, we = 0, sv = 0, acq = 0, wk = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat;
	logic [3:0] sel = 4'h0;
	logic ack, pa, pa_oe, pb, pb_oe, lva, lvb, rdy;
	logic [9:0] fx = 10'h000, fy = 10'h000, fz = 10'h000, ux = 10'h000, uy = 10'h000, uz = 10'h000, b;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	int error_cnt = 0, num_checks = 0, seed = 82019;
	always #5 clk_sys_in = ~clk_sys_in;
	motion_interrupt_controller #(.HOLD_TICK_CYCLES(4), .NEWDATA_LOW(8)) i_motion_interrupt_controller (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel), .wb_dat_out(rdat), .wb_ack_out(ack),
		.sample_valid_in(sv), .acq_start_in(acq), .dedicated_wake_in(wk), .accel_filt_x_in(fx),
		.accel_filt_y_in(fy), .accel_filt_z_in(fz), .accel_unfilt_x_in(ux), .accel_unfilt_y_in(uy),
		.accel_unfilt_z_in(uz), .irq_pin_a_out(pa), .irq_pin_a_oe_out(pa_oe), .irq_pin_b_out(pb),
		.irq_pin_b_oe_out(pb_oe));
	irq_host_model i_irq_host_model (.clk_sys_in(clk_sys_in), .pin_a_in(pa), .oe_a_in(pa_oe), .pin_b_in(pb),
		.oe_b_in(pb_oe), .level_a_out(lva), .level_b_out(lvb), .ready_out(rdy));
	// ============================================================
	// Bus and stimulus tasks
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v, input logic c);
		@(posedge clk_sys_in);
		exp_q.push_back({c, 24'h0, v});
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {idx[5:0], 2'b00};
		dat <= {24'h0, v};
		sel <= 4'h1;
		do
			@(posedge clk_sys_in);
		while (ack !== 1'b1);
		cyc <= 0;
		stb <= 0;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		bus(1, idx, v, 0);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] v);
		bus(0, idx, v, 1);
	endtask : rd
	task automatic smp(input logic [9:0] v);
		@(posedge clk_sys_in);
		sv <= 1;
		fx <= v;
		fy <= 10'($random(seed));
		fz <= 10'($random(seed));
		ux <= ~v;
		uy <= 10'($random(seed));
		uz <= 10'($random(seed));
		@(posedge clk_sys_in);
		sv <= 0;
		@(posedge clk_sys_in);
	endtask : smp
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		num_checks++;
		if (got !== want)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic close_out;
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	// ============================================================
	// Read-data monitor
	always @(posedge clk_sys_in)
		if (ack === 1'b1)
		begin
			e = exp_q.size() ? exp_q.pop_front() : 33'h1DEADBEEF;
			if (e[32] !== 1'b0)
				chk(rdat[7:0], e[7:0]);
		end
	initial
	begin
		#300000;
		error_cnt++;
		close_out();
	end
	// ============================================================
	// Scenarios
	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1;
		b = 10'($random(seed)) & 10'h0FF;
		wait (rdy === 1'b1);
		chk({7'h0, lva}, 8'h01);
		rd(REG_THRESHOLD, 8'h14);
		rd(8'h3F, 8'h00);
		smp(b);
		wr(REG_MAP_DATA, 8'h81);
		wr(REG_DATA_EN, 8'h10);
		repeat (12) @(posedge clk_sys_in);
		smp(b);
		rd(REG_DATA_STATUS, 8'h80);
		chk({6'h0, lva, lvb}, 8'h00);
		wr(REG_CLEAR_MODE, 8'h07);
		@(posedge clk_sys_in) acq <= 1;
		@(posedge clk_sys_in) acq <= 0;
		rd(REG_DATA_STATUS, 8'h00);
		chk({6'h0, lva, lvb}, 8'h03);
		wr(REG_DATA_EN, 8'h00);
		wr(REG_CLEAR_MODE, 8'h00);
		wr(REG_MAP_A, 8'h04);
		wr(REG_SLOPE_EN, 8'h01);
		smp(b);
		smp(b + 10'd20);
		rd(REG_SLOPE_STATUS, 8'h00);
		smp(b + 10'd41);
		rd(REG_SLOPE_STATUS, 8'h04);
		rd(REG_SLOPE_AXIS, 8'h01);
		chk({6'h0, lva, lvb}, 8'h01);
		smp(b + 10'd41);
		rd(REG_SLOPE_STATUS, 8'h00);
		smp(b);
		rd(REG_SLOPE_AXIS, 8'h09);
		smp(b);
		wr(REG_CLEAR_MODE, 8'h07);
		smp(b + 10'd41);
		smp(b + 10'd41);
		rd(REG_SLOPE_STATUS, 8'h04);
		wr(REG_CLEAR_MODE, 8'h87);
		rd(REG_SLOPE_STATUS, 8'h00);
		rd(REG_SLOPE_AXIS, 8'h00);
		wr(REG_CLEAR_MODE, 8'h09);
		smp(b);
		smp(b);
		repeat (10) @(posedge clk_sys_in);
		rd(REG_SLOPE_STATUS, 8'h00);
		chk({7'h0, lva}, 8'h01);
		wr(REG_CLEAR_MODE, 8'h07);
		smp(b + 10'd41);
		wr(REG_SLOPE_EN, 8'h00);
		rd(REG_SLOPE_STATUS, 8'h00);
		wr(REG_CLEAR_MODE, 8'h00);
		wr(REG_SLOPE_DUR, 8'h01);
		wr(REG_SLOPE_EN, 8'h01);
		smp(b);
		rd(REG_SLOPE_STATUS, 8'h00);
		smp(b + 10'd41);
		rd(REG_SLOPE_STATUS, 8'h04);
		smp(b + 10'd41);
		rd(REG_SLOPE_STATUS, 8'h04);
		smp(b + 10'd41);
		rd(REG_SLOPE_STATUS, 8'h00);
		wr(REG_SLOPE_EN, 8'h00);
		wr(REG_SRC_SEL, 8'h04);
		@(posedge clk_sys_in) wk <= 1;
		smp(b);
		smp(b + 10'd41);
		rd(REG_SLOPE_STATUS, 8'h04);
		rd(REG_SLOPE_AXIS, 8'h09);
		@(posedge clk_sys_in) wk <= 0;
		rd(REG_SLOPE_STATUS, 8'h00);
		wr(REG_PIN_CFG, 8'h01);
		repeat (2) @(posedge clk_sys_in);
		chk({7'h0, pa}, 8'h00);
		wr(REG_PIN_CFG, 8'h02);
		repeat (2) @(posedge clk_sys_in);
		chk({6'h0, pa_oe, lva}, 8'h01);
		repeat (3) @(posedge clk_sys_in);
		close_out();
	end
endmodule : motion_interrupt_controller_tb
`default_nettype wire
